// ### core/iord_pkg.sv
// Package of constants for the I/O register space decoder
package iord_pkg;
    // ==========================================================
    // Address map
    localparam logic [7:0] IO_LAST       = 8'h3f; // Top of I/O space
    localparam logic [7:0] BIT_OP_LAST   = 8'h1f; // Top of bit-op area
    localparam logic [7:0] DATA_OFFSET   = 8'h20; // Data-space offset
    localparam logic [7:0] EXT_FIRST     = 8'h60; // Extended area start
    localparam logic [7:0] EXT_LAST      = 8'hff; // Extended area end
    localparam int         IO_LOCATIONS  = 64;    // I/O address count
    // ==========================================================
    // Register offsets (I/O addresses)
    localparam logic [5:0] TMR1_FLAGS    = 6'h16;
    localparam logic [5:0] TMR2_FLAGS    = 6'h17;
    localparam logic [5:0] PCHG_FLAGS    = 6'h1b;
    localparam logic [5:0] EXTIRQ_FLAGS  = 6'h1c;
    localparam logic [5:0] EXTIRQ_MASK   = 6'h1d;
    localparam logic [5:0] SCRATCH0      = 6'h1e;
    localparam logic [5:0] NVM_CTRL      = 6'h1f;
    localparam logic [5:0] NVM_DATA      = 6'h20;
    localparam logic [5:0] NVM_ADDR_LO   = 6'h21;
    localparam logic [5:0] NVM_ADDR_HI   = 6'h22;
    localparam logic [5:0] TMR_GLOBAL    = 6'h23;
    localparam logic [5:0] TMR0_CTRL_A   = 6'h24;
    localparam logic [5:0] TMR0_CTRL_B   = 6'h25;
    localparam logic [5:0] TMR0_COUNT    = 6'h26;
    localparam logic [5:0] TMR0_CMP_A    = 6'h27;
    localparam logic [5:0] TMR0_CMP_B    = 6'h28;
    localparam logic [5:0] SCRATCH1      = 6'h2a;
    localparam logic [5:0] SCRATCH2      = 6'h2b;
    localparam logic [5:0] SPER_CTRL     = 6'h2c;
    localparam logic [5:0] SPER_STATUS   = 6'h2d;
    localparam logic [5:0] SPER_DATA     = 6'h2e;
    localparam logic [5:0] CMP_CTRL      = 6'h30;
    localparam logic [5:0] SLEEP_CTRL    = 6'h33;
    localparam logic [5:0] RST_CAUSE     = 6'h34;
    localparam logic [5:0] CORE_CTRL     = 6'h35;
    localparam logic [5:0] SELFPROG_CTRL = 6'h37;
    // ==========================================================
    // Implemented bit masks of the flag registers
    localparam logic [7:0] TMR1_MASK     = 8'h27;
    localparam logic [7:0] TMR2_MASK     = 8'h07;
    localparam logic [7:0] PCHG_MASK     = 8'h07;
    localparam logic [7:0] EXTIRQ_BITS   = 8'h03;
    localparam logic [7:0] REG_RESET     = 8'h00; // Value after reset
    // ==========================================================
    // Access kinds
    typedef enum logic [5:0] {
        OP_IO_READ    = 6'b000001,
        OP_IO_WRITE   = 6'b000010,
        OP_BIT_SET    = 6'b000100,
        OP_BIT_CLEAR  = 6'b001000,
        OP_MEM_READ   = 6'b010000,
        OP_MEM_WRITE  = 6'b100000
    } iord_op_t;
endpackage

// ### core/iord_addr_map.sv
// Address translator from access kind and address to I/O index
`timescale 1ns/1ps
module iord_addr_map (
    input  wire logic [7:0] addr,      // Raw address from core
    input  wire logic [5:0] op,        // Access kind, one-hot
    output logic            hit,       // Address maps to I/O space
    output logic [5:0]      ioIdx      // I/O index
);
    logic [7:0] memIdx;

    // Translate data-space addresses down by the fixed offset
    always_comb begin
        memIdx = addr - iord_pkg::DATA_OFFSET;
        hit    = 1'b0;
        ioIdx  = addr[5:0];
        if (op == iord_pkg::OP_MEM_READ || op == iord_pkg::OP_MEM_WRITE)
        begin
            hit   = addr >= iord_pkg::DATA_OFFSET
                 && memIdx <= iord_pkg::IO_LAST;
            ioIdx = memIdx[5:0];
        end else if (op == iord_pkg::OP_BIT_SET
                  || op == iord_pkg::OP_BIT_CLEAR) begin
            hit = addr <= iord_pkg::BIT_OP_LAST;
        end else if (op == iord_pkg::OP_IO_READ
                  || op == iord_pkg::OP_IO_WRITE) begin
            hit = addr <= iord_pkg::IO_LAST;
        end
    end
endmodule // iord_addr_map

// ### core/iord_decoder.sv
// I/O register space decoder with the upper peripheral register bank
// Functional notes
// - Flag bits clear on a written one and ignore a written zero.
// - Bit set or clear changes only the addressed bit, flags included.
// - Bit set and clear are accepted only at I/O addresses 0x00-0x1f.
// - Dedicated I/O reads and writes use I/O addresses 0x00-0x3f.
// - Data-space address of an I/O register is its I/O address + 0x20.
// - The extended area 0x60-0xff is reached by load and store only.
// - The dedicated I/O address field encodes exactly 64 locations.
// - Bit tests are supported at the same low 32 I/O locations.
`timescale 1ns/1ps
module iord_decoder #(
    parameter int IO_SIZE = iord_pkg::IO_LOCATIONS // I/O locations
) (
    input  wire logic       core_clk,     // System clock
    input  wire logic       rst_n,        // Synchronous reset, low
    input  wire logic       accValid,     // Access strobe
    input  wire logic [5:0] accOp,        // Access kind, one-hot
    input  wire logic [7:0] accAddr,      // Address of access
    input  wire logic [2:0] accBit,       // Bit index for bit ops
    input  wire logic [7:0] accWdata,     // Write data
    input  wire logic [7:0] tmr1Event,    // Timer 1 event pulses
    input  wire logic [7:0] tmr2Event,    // Timer 2 event pulses
    input  wire logic [7:0] pchgEvent,    // Pin change event pulses
    input  wire logic [7:0] extIrqEvent,  // External irq pulses
    output logic [7:0]      accRdata,     // Read data
    output logic            accRvalid,    // Read data valid
    output logic            bitTestTrue,  // Tested bit is set
    output logic            bitTestValid, // Bit test result valid
    output logic            extSelect,    // Extended area access
    output logic [7:0]      extIrqMask_q, // External irq enables
    output logic            accError_q    // Access refused
);
    // ==========================================================
    // Decode
    logic            ioHit;
    logic [5:0]      ioIdx;
    logic            isWrite;
    logic            isBitOp;
    logic            isMem;
    logic            isTest;
    logic [7:0]      bitMask;
    logic [7:0]      curVal;
    logic [7:0]      newVal;
    logic            doWrite;
    logic [7:0]      w1c;
    logic [7:0]      regs_q [0:IO_SIZE-1];
    logic            testSet_d;

    iord_addr_map uMap (
        .addr  (accAddr),
        .op    (accOp),
        .hit   (ioHit),
        .ioIdx (ioIdx)
    );

    // Whether an I/O index names a real register
    function automatic logic isMapped(input logic [5:0] idx);
        case (idx)
            iord_pkg::TMR1_FLAGS, iord_pkg::TMR2_FLAGS,
            iord_pkg::PCHG_FLAGS, iord_pkg::EXTIRQ_FLAGS,
            iord_pkg::EXTIRQ_MASK, iord_pkg::SCRATCH0,
            iord_pkg::NVM_CTRL, iord_pkg::NVM_DATA,
            iord_pkg::NVM_ADDR_LO, iord_pkg::NVM_ADDR_HI,
            iord_pkg::TMR_GLOBAL, iord_pkg::TMR0_CTRL_A,
            iord_pkg::TMR0_CTRL_B, iord_pkg::TMR0_COUNT,
            iord_pkg::TMR0_CMP_A, iord_pkg::TMR0_CMP_B,
            iord_pkg::SCRATCH1, iord_pkg::SCRATCH2,
            iord_pkg::SPER_CTRL, iord_pkg::SPER_STATUS,
            iord_pkg::SPER_DATA, iord_pkg::CMP_CTRL,
            iord_pkg::SLEEP_CTRL, iord_pkg::RST_CAUSE,
            iord_pkg::CORE_CTRL, iord_pkg::SELFPROG_CTRL: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // Write-one-to-clear mask for a register index
    function automatic logic [7:0] w1cMask(input logic [5:0] idx);
        case (idx)
            iord_pkg::TMR1_FLAGS:   w1cMask = iord_pkg::TMR1_MASK;
            iord_pkg::TMR2_FLAGS:   w1cMask = iord_pkg::TMR2_MASK;
            iord_pkg::PCHG_FLAGS:   w1cMask = iord_pkg::PCHG_MASK;
            iord_pkg::EXTIRQ_FLAGS: w1cMask = iord_pkg::EXTIRQ_BITS;
            default:                w1cMask = 8'h00;
        endcase
    endfunction

    // Access classification and write value
    always_comb begin
        isWrite = accOp == iord_pkg::OP_IO_WRITE
               || accOp == iord_pkg::OP_MEM_WRITE;
        isBitOp = accOp == iord_pkg::OP_BIT_SET
               || accOp == iord_pkg::OP_BIT_CLEAR;
        isMem   = accOp == iord_pkg::OP_MEM_READ
               || accOp == iord_pkg::OP_MEM_WRITE;
        isTest  = accOp == iord_pkg::OP_IO_READ
               && accAddr <= iord_pkg::BIT_OP_LAST;
        bitMask = 8'h01 << accBit;
        curVal  = isMapped(ioIdx) ? regs_q[ioIdx] : 8'h00;
        w1c     = w1cMask(ioIdx);
        doWrite = accValid && ioHit && isMapped(ioIdx)
               && (isWrite || isBitOp);
        newVal  = curVal;
        if (accOp == iord_pkg::OP_BIT_SET) begin
            // Only the addressed bit moves; flags treat it as a one
            newVal = (curVal & ~w1c) | bitMask;
            newVal = newVal | (curVal & w1c & ~bitMask);
            if ((w1c & bitMask) != 8'h00)
                newVal = curVal & ~bitMask;
        end else if (accOp == iord_pkg::OP_BIT_CLEAR) begin
            newVal = (w1c & bitMask) != 8'h00 ? curVal
                                              : curVal & ~bitMask;
        end else if (isWrite) begin
            newVal = (accWdata & ~w1c) | (curVal & w1c & ~accWdata);
        end
    end

    // ==========================================================
    // Register bank with flag capture, set beats clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < IO_SIZE; i++)
                regs_q[i] <= iord_pkg::REG_RESET;
        end else begin
            if (doWrite)
                regs_q[ioIdx] <= newVal;
            regs_q[iord_pkg::TMR1_FLAGS] <= (doWrite
                && ioIdx == iord_pkg::TMR1_FLAGS ? newVal
                : regs_q[iord_pkg::TMR1_FLAGS])
                | (tmr1Event & iord_pkg::TMR1_MASK);
            regs_q[iord_pkg::TMR2_FLAGS] <= (doWrite
                && ioIdx == iord_pkg::TMR2_FLAGS ? newVal
                : regs_q[iord_pkg::TMR2_FLAGS])
                | (tmr2Event & iord_pkg::TMR2_MASK);
            regs_q[iord_pkg::PCHG_FLAGS] <= (doWrite
                && ioIdx == iord_pkg::PCHG_FLAGS ? newVal
                : regs_q[iord_pkg::PCHG_FLAGS])
                | (pchgEvent & iord_pkg::PCHG_MASK);
            regs_q[iord_pkg::EXTIRQ_FLAGS] <= (doWrite
                && ioIdx == iord_pkg::EXTIRQ_FLAGS ? newVal
                : regs_q[iord_pkg::EXTIRQ_FLAGS])
                | (extIrqEvent & iord_pkg::EXTIRQ_BITS);
        end
    end

    // ==========================================================
    // Read path and bit test result
    always_comb begin
        testSet_d = (curVal & bitMask) != 8'h00;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            accRdata     <= 8'h00;
            accRvalid    <= 1'b0;
            bitTestTrue  <= 1'b0;
            bitTestValid <= 1'b0;
        end else begin
            accRvalid    <= accValid && ioHit && !isWrite && !isBitOp;
            accRdata     <= (accValid && ioHit && !isWrite) ? curVal
                                                            : 8'h00;
            bitTestValid <= accValid && isTest;
            bitTestTrue  <= accValid && isTest && testSet_d;
        end
    end

    // Extended area select and refused access flag
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            extSelect  <= 1'b0;
            accError_q <= 1'b0;
        end else begin
            extSelect  <= accValid && isMem
                       && accAddr >= iord_pkg::EXT_FIRST;
            accError_q <= accValid && !ioHit
                       && !(isMem && accAddr >= iord_pkg::EXT_FIRST);
        end
    end

    // Mirror of the external irq enable register
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            extIrqMask_q <= 8'h00;
        else
            extIrqMask_q <= regs_q[iord_pkg::EXTIRQ_MASK];
    end

    // ==========================================================
    // Checks
    flag_set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        tmr1Event[0] |=> regs_q[iord_pkg::TMR1_FLAGS][0])
        else $error("timer flag event lost");
    w1c_clears_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        accValid && accOp == iord_pkg::OP_IO_WRITE
        && accAddr == 8'h1c && accWdata[0] && !extIrqEvent[0]
        |=> !regs_q[iord_pkg::EXTIRQ_FLAGS][0])
        else $error("flag not cleared by one");
    bit_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        accValid && accOp == iord_pkg::OP_BIT_SET && accAddr == 8'h1e
        |=> (regs_q[iord_pkg::SCRATCH0] & ~(8'h01 << $past(accBit)))
            == ($past(regs_q[iord_pkg::SCRATCH0])
            & ~(8'h01 << $past(accBit))))
        else $error("bit op changed other bits");
    bitop_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        accValid && isBitOp && accAddr > 8'h1f |=> accError_q)
        else $error("high bit op accepted");
    io_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        accValid && accOp == iord_pkg::OP_IO_READ && accAddr > 8'h3f
        |=> accError_q && !accRvalid)
        else $error("I/O op beyond 64 locations");
    mem_offset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        accValid && accOp == iord_pkg::OP_MEM_READ && accAddr == 8'h3e
        |=> accRvalid && accRdata == $past(regs_q[iord_pkg::SCRATCH0]))
        else $error("data space offset wrong");
    ext_mem_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        accValid && accOp == iord_pkg::OP_IO_WRITE && accAddr >= 8'h60
        |=> !extSelect && accError_q)
        else $error("extended area via I/O op");
    bit_test_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bitTestValid |-> $past(accAddr) <= 8'h1f)
        else $error("bit test outside low area");
    reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        accValid && accOp == iord_pkg::OP_IO_READ && accAddr == 8'h36
        |=> accRdata == 8'h00)
        else $error("reserved location read nonzero");
endmodule // iord_decoder

// ### bench/iord_core_model.sv
// Core-side model that issues I/O and load/store accesses to the decoder
`timescale 1ns/1ps
module iord_core_model (
    input  wire logic       core_clk,     // System clock
    output logic            accValid,     // Access strobe
    output logic [5:0]      accOp,        // Access kind
    output logic [7:0]      accAddr,      // Address of access
    output logic [2:0]      accBit,       // Bit index
    output logic [7:0]      accWdata,     // Write data
    input  wire logic [7:0] accRdata,     // Read data
    input  wire logic       accRvalid,    // Read data valid
    input  wire logic       bitTestTrue,  // Tested bit result
    input  wire logic       bitTestValid, // Bit test valid
    input  wire logic       extSelect,    // Extended area access
    input  wire logic       accError_q    // Access refused
);
    logic [7:0] rData; // Captured read data
    logic [4:0] ans;   // {rvalid, testValid, testTrue, ext, error}

    // Idle bus at time zero
    initial begin
        accValid = 1'b0;
        accOp = 6'h00;
        accAddr = 8'h00;
        accBit = 3'h0;
        accWdata = 8'h00;
    end

    // One access: drive, hold over the taking edge, capture answer, release
    // The answer stands only for the cycle after the taking edge
    task automatic acc(input logic [5:0] op, input logic [7:0] a,
                       input logic [2:0] b, input logic [7:0] d);
        @(negedge core_clk);
        accValid = 1'b1;
        accOp = op;
        accAddr = a;
        accBit = b;
        accWdata = d;
        @(negedge core_clk);
        rData = accRdata;
        ans = {accRvalid, bitTestValid, bitTestTrue, extSelect, accError_q};
        accValid = 1'b0;
        accOp = ~accOp;      // Released lines no longer show the last value
        accAddr = ~accAddr;
        accBit = ~accBit;
        accWdata = ~accWdata;
    endtask
endmodule // iord_core_model

// ### bench/iord_decoder_tb_top.sv
// Self-checking testbench of the I/O register space decoder
`timescale 1ns/1ps
module iord_decoder_tb_top;
    logic        core_clk, rst_n;
    logic [7:0]  ev1, ev2, evP, evX, accRdata, extIrqMask_q;
    logic [7:0]  accAddr, accWdata, shadow[64], fa, fm, r, d;
    logic [5:0]  accOp;
    logic [2:0]  accBit;
    logic        accValid, accRvalid, bitTestTrue, bitTestValid;
    logic        extSelect, accError_q;
    logic [31:0] seed;
    int          failures, samples_checked, cycles, i, k;
    // Full-byte RW registers used as random write targets
    logic [7:0]  rwRegs[9] = '{8'h1e, 8'h20, 8'h21, 8'h26, 8'h27,
                               8'h28, 8'h2a, 8'h2b, 8'h2e};
    logic [7:0]  flagAddr[4] = '{8'h16, 8'h17, 8'h1b, 8'h1c};
    logic [7:0]  flagMask[4] = '{iord_pkg::TMR1_MASK, iord_pkg::TMR2_MASK,
                                 iord_pkg::PCHG_MASK, iord_pkg::EXTIRQ_BITS};

    // ==========================================================
    // Clock, timeout
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            report_and_stop();
        end
    end

    iord_decoder dut (.core_clk(core_clk), .rst_n(rst_n),
        .accValid(accValid), .accOp(accOp), .accAddr(accAddr),
        .accBit(accBit), .accWdata(accWdata), .tmr1Event(ev1),
        .tmr2Event(ev2), .pchgEvent(evP), .extIrqEvent(evX),
        .accRdata(accRdata), .accRvalid(accRvalid),
        .bitTestTrue(bitTestTrue), .bitTestValid(bitTestValid),
        .extSelect(extSelect), .extIrqMask_q(extIrqMask_q),
        .accError_q(accError_q));
    iord_core_model core (.core_clk(core_clk), .accValid(accValid),
        .accOp(accOp), .accAddr(accAddr), .accBit(accBit),
        .accWdata(accWdata), .accRdata(accRdata), .accRvalid(accRvalid),
        .bitTestTrue(bitTestTrue), .bitTestValid(bitTestValid),
        .extSelect(extSelect), .accError_q(accError_q));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: flags %b want %b", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        core_clk = 0;
        rst_n = 0;
        {ev1, ev2, evP, evX} = '0;
        seed = 32'd67;
        foreach (shadow[j]) shadow[j] = 8'h00;
        repeat (3) @(negedge core_clk);
        rst_n = 1;
        // All I/O locations read zero after reset, bit tests in low half
        for (i = 0; i < 64; i++) begin
            core.acc(iord_pkg::OP_IO_READ, i[7:0], 3'h0, 8'h00);
            chk8(core.rData, 8'h00);
            chk5(core.ans, {1'b1, i < 32, 3'b000});
        end
        // Random writes and reads, I/O and data-space forms mixed
        for (i = 0; i < 40; i++) begin
            seed = xorshift(seed);
            r = rwRegs[seed[11:8] % 9];
            d = seed[23:16]; // Full-byte registers, no reserved bits
            shadow[r[5:0]] = d;
            core.acc(seed[0] ? iord_pkg::OP_MEM_WRITE : iord_pkg::OP_IO_WRITE,
                     seed[0] ? r + 8'h20 : r, seed[4:2], d);
            core.acc(seed[1] ? iord_pkg::OP_MEM_READ : iord_pkg::OP_IO_READ,
                     seed[1] ? r + 8'h20 : r, seed[4:2], 8'h00);
            chk8(core.rData, d);
        end
        // Bit set then clear on every bit of scratch 0, tested by reads
        for (k = 0; k < 16; k++) begin
            core.acc(k < 8 ? iord_pkg::OP_BIT_SET : iord_pkg::OP_BIT_CLEAR,
                     8'h1e, k[2:0], 8'h00);
            shadow[30][k[2:0]] = (k < 8);
            core.acc(iord_pkg::OP_IO_READ, 8'h1e, k[2:0], 8'h00);
            chk8(core.rData, shadow[30]);
            chk5(core.ans, {2'b11, k < 8, 2'b00});
        end
        // Refused and forwarded accesses
        core.acc(iord_pkg::OP_BIT_SET, 8'h2a, 3'h7, 8'h00);
        chk5(core.ans, 5'b00001);
        core.acc(iord_pkg::OP_IO_READ, 8'h2a, 3'h7, 8'h00);
        chk8(core.rData, shadow[42]);
        chk5(core.ans, {1'b1, 1'b0, 3'b000});
        core.acc(iord_pkg::OP_IO_READ, 8'h40, 3'h0, 8'h00);
        chk5(core.ans[0], 1'b1);
        core.acc(iord_pkg::OP_MEM_READ, 8'h1f, 3'h0, 8'h00);
        chk5(core.ans[0], 1'b1);
        core.acc(iord_pkg::OP_MEM_WRITE, 8'h60, 3'h0, 8'h5a);
        chk5(core.ans[1:0], 2'b10);
        core.acc(iord_pkg::OP_IO_WRITE, 8'h60, 3'h0, 8'h5a);
        chk5(core.ans[1:0], 2'b01);
        // Event flags: set, one to clear, zero kept, bit ops isolated
        @(negedge core_clk);
        {ev1, ev2, evP, evX} = '1;
        @(negedge core_clk);
        {ev1, ev2, evP, evX} = '0;
        for (k = 0; k < 4; k++) begin
            fa = flagAddr[k];
            fm = flagMask[k];
            core.acc(iord_pkg::OP_IO_READ, fa, 3'h0, 8'h00);
            chk8(core.rData, fm);
            core.acc(iord_pkg::OP_IO_WRITE, fa, 3'h0, 8'h01);
            core.acc(iord_pkg::OP_IO_WRITE, fa, 3'h0, 8'h00);
            core.acc(iord_pkg::OP_BIT_CLEAR, fa, 3'h1, 8'h00);
            core.acc(iord_pkg::OP_IO_READ, fa, 3'h0, 8'h00);
            chk8(core.rData, fm & 8'hfe);
            core.acc(iord_pkg::OP_BIT_SET, fa, 3'h1, 8'h00);
            core.acc(iord_pkg::OP_MEM_READ, fa + 8'h20, 3'h0, 8'h00);
            chk8(core.rData, fm & 8'hfc);
        end
        // Mask register copy appears one cycle after the write lands
        core.acc(iord_pkg::OP_IO_WRITE, 8'h1d, 3'h0, 8'h03);
        @(negedge core_clk);
        chk8(extIrqMask_q, 8'h03);
        // Second reset clears stored state
        rst_n = 0;
        @(negedge core_clk);
        rst_n = 1;
        core.acc(iord_pkg::OP_IO_READ, 8'h2a, 3'h0, 8'h00);
        chk8(core.rData, 8'h00);
        report_and_stop();
    end
endmodule // iord_decoder_tb_top
